// ===== ppsm_pkg.sv
// Operation
// - Set pointer picks the set for record access; range 0..267, default 266.
// - Sets: 0-255 standard, 256-258 homing, 259/260 jog, 266 bus.
// - Record subindex 0-4: target, profile vel, end vel, accel, decel.
// - Subindex 5 write stores one value to both accel and decel.
// - Subindex 5 read returns only the acceleration.
// - Start selector 0..254 standard sets, 255 (default) means bus set.
// - Jerk mode 0 zeroes jerk once after reset or on mode write.
// - Jerk mode 1 recomputes filter time from accel and velocity per call.
// - A call is the bus start command; launch may wait for a hold.
// - Override 0..2000 per mille scales running velocity at once.
// - Override is 1000 after reset and never goes to stored config.
// - Override leaves accel alone and is frozen while braking.
// - Positioning mode refuses targets outside limits, optional message.
// - Limits are signed 32-bit, defaults most negative and most positive.
// - Bus set writes are offered to non-volatile storage.
package ppsm_pkg;
   // Parameter numbers
   localparam logic [15:0] PNU_SET_PTR = 16'h03e8;
   localparam logic [15:0] PNU_RECORD = 16'h03e9;
   localparam logic [15:0] PNU_START_SEL = 16'h03ea;
   localparam logic [15:0] PNU_JERK_MODE = 16'h03eb;
   localparam logic [15:0] PNU_OVERRIDE = 16'h03ec;
   localparam logic [15:0] PNU_LIMITS = 16'h03ed;
   // Record subindices
   localparam logic [2:0] F_TGT = 3'h0;
   localparam logic [2:0] F_PVEL = 3'h1;
   localparam logic [2:0] F_EVEL = 3'h2;
   localparam logic [2:0] F_ACC = 3'h3;
   localparam logic [2:0] F_DEC = 3'h4;
   localparam logic [2:0] F_BOTH = 3'h5;
   localparam int NUM_FIELDS = 5;
   // Set numbering
   localparam int NUM_SETS = 268;
   localparam logic [15:0] SET_MAX = 16'h010b;
   localparam logic [15:0] SET_HOME0 = 16'h0100;
   localparam logic [15:0] SET_JOG_POS = 16'h0103;
   localparam logic [15:0] SET_JOG_NEG = 16'h0104;
   localparam logic [15:0] SET_BUS = 16'h010a;
   localparam logic [7:0] START_BUS_CODE = 8'hff;
   // Limits of other values
   localparam logic [15:0] JERK_MODE_MAX = 16'h0001;
   localparam logic [15:0] OVR_MAX = 16'h07d0;
   // Reset values
   localparam logic [15:0] OVR_FULL = 16'h03e8;
   localparam logic [31:0] RST_TGT = 32'h0000_0000;
   localparam logic [31:0] RST_PVEL = 32'h0000_03e8;
   localparam logic [31:0] RST_EVEL = 32'h0000_0000;
   localparam logic [31:0] RST_ACC = 32'h0000_2710;
   localparam logic [31:0] LIM_LO_RST = 32'h8000_0000;
   localparam logic [31:0] LIM_HI_RST = 32'h7fff_ffff;
endpackage : ppsm_pkg

// ===== ppsm_divider.sv
`timescale 1ns/100ps
// Unsigned restoring divider, one quotient bit per cycle
module ppsm_divider (
   input wire logic i_mclk, // System clock
   input wire logic i_resetn, // Async reset, active low
   input wire logic i_go, // Start pulse, restarts a running division
   input wire logic [31:0] i_num, // Dividend
   input wire logic [31:0] i_den, // Divisor
   output logic [31:0] o_quot, // Quotient, held until next go
   output logic o_done // One-cycle pulse when quotient valid
);
   typedef struct packed {
      logic busy;
      logic [5:0] cnt;
      logic [31:0] rem;
      logic [31:0] quo;
      logic [31:0] den;
      logic done;
   } ppsm_div_s;
   ppsm_div_s q, d;
   logic [32:0] trial;

   // Shift-subtract step; zero divisor yields all ones
   always_comb begin
      d = q;
      d.done = 1'b0;
      trial = {q.rem, q.quo[31]} - {1'b0, q.den};
      if (i_go) begin
         d.busy = 1'b1;
         d.cnt = 6'h20;
         d.rem = 32'h0000_0000;
         d.quo = i_num;
         d.den = i_den;
      end else if (q.busy) begin
         if (trial[32]) begin
            d.rem = {q.rem[30:0], q.quo[31]};
            d.quo = {q.quo[30:0], 1'b0};
         end else begin
            d.rem = trial[31:0];
            d.quo = {q.quo[30:0], 1'b1};
         end
         d.cnt = q.cnt - 6'h01;
         if (q.cnt == 6'h01) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_quot = q.quo;
   assign o_done = q.done;
endmodule // ppsm_divider

// ===== ppsm_scale.sv
`timescale 1ns/100ps
// Velocity times override per mille, registered
module ppsm_scale (
   input wire logic i_mclk, // System clock
   input wire logic i_resetn, // Async reset, active low
   input wire logic signed [31:0] i_vel, // Profile velocity
   input wire logic [15:0] i_ovr, // Override, per mille
   output logic signed [31:0] o_vel // Scaled velocity
);
   typedef struct packed {
      logic signed [31:0] vel;
   } ppsm_scl_s;
   ppsm_scl_s q, d;
   logic signed [48:0] prod;
   logic signed [48:0] quot;

   // Override never exceeds 2000, so the result is at most twice the velocity; only bits 31:0 are kept
   always_comb begin
      prod = i_vel * $signed({1'b0, i_ovr});
      quot = prod / 49'sd1000;
      d.vel = quot[31:0];
   end

   // State register
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_vel = q.vel;
endmodule // ppsm_scale

// ===== ppsm_param_set.sv
`timescale 1ns/100ps
// Positioning parameter set: set records, start selector, jerk, override
module ppsm_param_set
   import ppsm_pkg::*;
(
   input wire logic i_mclk, // System clock, 100 MHz
   input wire logic i_resetn, // Async reset, active low
   input wire logic i_req, // Parameter access request
   input wire logic i_wr, // 1 write, 0 read
   input wire logic [15:0] i_pnu, // Parameter number
   input wire logic [7:0] i_sub, // Subindex
   input wire logic [31:0] i_wdata, // Write data
   output logic o_ready, // Accepts accesses (low during init)
   output logic o_ack, // Access answered, pulse
   output logic o_err, // Access rejected, with o_ack
   output logic [31:0] o_rdata, // Read data
   input wire logic i_start, // Bus start command, pulse
   input wire logic i_pos_mode, // Positioning mode active
   input wire logic i_hold, // Set option delays the actual start
   input wire logic i_braking, // Running move is decelerating
   input wire logic i_msg_enable, // Raise message on limit refusal
   output logic o_launch, // Actual start of called set, pulse
   output logic [8:0] o_call_set, // Set number called
   output logic [31:0] o_call_target, // Target of called set
   output logic [31:0] o_call_accel, // Acceleration of called set
   output logic [31:0] o_call_decel, // Deceleration of called set
   output logic signed [31:0] o_vel_cmd, // Override-scaled velocity
   output logic o_refused, // Start refused by limits, pulse
   output logic o_limit_msg, // Limit message, pulse
   output logic [31:0] o_filter_time, // Jerk filter time, 0 in mode 0
   output logic o_filter_valid, // Filter time updated, pulse
   output logic o_nv_wr, // Bus set field changed, pulse
   output logic [2:0] o_nv_field, // Field written
   output logic [31:0] o_nv_data // Value written
);
   typedef struct packed {
      logic ready;
      logic [8:0] init_set;
      logic [2:0] init_fld;
      logic [15:0] set_ptr;
      logic [7:0] start_sel;
      logic [15:0] jerk_mode;
      logic [15:0] ovr;
      logic [15:0] ovr_applied;
      logic [31:0] lim_lo;
      logic [31:0] lim_hi;
      logic ack;
      logic err;
      logic [31:0] rdata;
      logic call_pend;
      logic [8:0] call_set;
      logic [31:0] call_tgt;
      logic [31:0] call_vel;
      logic [31:0] call_acc;
      logic [31:0] call_dec;
      logic launch;
      logic refused;
      logic limit_msg;
      logic [31:0] filter_time;
      logic filter_valid;
      logic nv_wr;
      logic [2:0] nv_fld;
      logic [31:0] nv_data;
   } ppsm_state_s;

   ppsm_state_s q, d;
   logic [31:0] rec_mem [0:NUM_SETS-1][0:NUM_FIELDS-1];
   logic [NUM_FIELDS-1:0] mem_we;
   logic [8:0] mem_set;
   logic [31:0] mem_wd;
   logic [8:0] ptr_set;
   logic [8:0] st_set;
   logic in_limits;
   logic acc_req;
   logic div_go;
   logic div_done;
   logic [31:0] div_quot;

   // Reset contents of one record field
   function automatic logic [31:0] f_default(input logic [2:0] fld);
      unique case (fld)
         F_PVEL: f_default = RST_PVEL;
         F_ACC, F_DEC: f_default = RST_ACC;
         F_EVEL: f_default = RST_EVEL;
         default: f_default = RST_TGT;
      endcase
   endfunction

   // Start selector to set number; 255 cannot reach standard set 255
   function automatic logic [8:0] f_start_set(input logic [7:0] sel);
      f_start_set = (sel == START_BUS_CODE) ? SET_BUS[8:0]
                                            : {1'b0, sel};
   endfunction

   assign acc_req = i_req && q.ready;
   assign ptr_set = q.set_ptr[8:0];
   assign st_set = f_start_set(q.start_sel);
   assign in_limits = ($signed(rec_mem[st_set][F_TGT]) >= $signed(q.lim_lo))
                   && ($signed(rec_mem[st_set][F_TGT]) <= $signed(q.lim_hi));

   // Access decode, call handling and init sweep
   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.err = 1'b0;
      d.launch = 1'b0;
      d.refused = 1'b0;
      d.limit_msg = 1'b0;
      d.filter_valid = 1'b0;
      d.nv_wr = 1'b0;
      mem_we = '0;
      mem_set = ptr_set;
      mem_wd = i_wdata;
      div_go = 1'b0;
      if (!q.ready) begin
         // Sweep every field to its default; memory has no reset
         mem_we[q.init_fld] = 1'b1;
         mem_set = q.init_set;
         mem_wd = f_default(q.init_fld);
         d.init_fld = q.init_fld + 3'h1;
         if (q.init_fld == F_DEC) begin
            d.init_fld = F_TGT;
            d.init_set = q.init_set + 9'h001;
            if (q.init_set == SET_MAX[8:0]) begin
               d.ready = 1'b1;
               if (q.jerk_mode == 16'h0000) begin
                  d.filter_time = 32'h0000_0000;
                  d.filter_valid = 1'b1;
               end
            end
         end
      end
      if (acc_req) begin
         d.ack = 1'b1;
         d.rdata = 32'h0000_0000;
         unique case (i_pnu)
            PNU_SET_PTR: begin
               if (i_wr) begin
                  if (i_wdata[31:16] == 16'h0000 && i_wdata[15:0] <= SET_MAX)
                     d.set_ptr = i_wdata[15:0];
                  else
                     d.err = 1'b1;
               end
               d.rdata = {16'h0000, q.set_ptr};
            end
            PNU_RECORD: begin
               if (i_sub > {5'h00, F_BOTH}) begin
                  d.err = 1'b1;
               end else if (i_wr) begin
                  if (i_sub[2:0] == F_BOTH)
                     mem_we[F_ACC] = 1'b1;
                  if (i_sub[2:0] == F_BOTH)
                     mem_we[F_DEC] = 1'b1;
                  else
                     mem_we[i_sub[2:0]] = 1'b1;
                  if (q.set_ptr == SET_BUS) begin
                     d.nv_wr = 1'b1;
                     d.nv_fld = i_sub[2:0];
                     d.nv_data = i_wdata;
                  end
               end else if (i_sub[2:0] == F_BOTH) begin
                  d.rdata = rec_mem[ptr_set][F_ACC];
               end else begin
                  d.rdata = rec_mem[ptr_set][i_sub[2:0]];
               end
            end
            PNU_START_SEL: begin
               if (i_wr) begin
                  if (i_wdata[31:8] == 24'h00_0000)
                     d.start_sel = i_wdata[7:0];
                  else
                     d.err = 1'b1;
               end
               d.rdata = {24'h00_0000, q.start_sel};
            end
            PNU_JERK_MODE: begin
               if (i_wr) begin
                  if (i_wdata[31:16] == 16'h0000
                      && i_wdata[15:0] <= JERK_MODE_MAX) begin
                     d.jerk_mode = i_wdata[15:0];
                     if (i_wdata[15:0] == 16'h0000) begin
                        d.filter_time = 32'h0000_0000;
                        d.filter_valid = 1'b1;
                     end
                  end else begin
                     d.err = 1'b1;
                  end
               end
               d.rdata = {16'h0000, q.jerk_mode};
            end
            PNU_OVERRIDE: begin
               if (i_wr) begin
                  if (i_wdata[31:16] == 16'h0000 && i_wdata[15:0] <= OVR_MAX)
                     d.ovr = i_wdata[15:0];
                  else
                     d.err = 1'b1;
               end
               d.rdata = {16'h0000, q.ovr};
            end
            PNU_LIMITS: begin
               if (i_sub > 8'h01) begin
                  d.err = 1'b1;
               end else if (i_wr) begin
                  if (i_sub[0])
                     d.lim_hi = i_wdata;
                  else
                     d.lim_lo = i_wdata;
               end
               d.rdata = i_sub[0] ? q.lim_hi : q.lim_lo;
            end
            default: d.err = 1'b1;
         endcase
         if (i_wr || d.err)
            d.rdata = 32'h0000_0000;
      end
      // The call is the bus command itself; a pending call ignores more
      if (i_start && q.ready && !q.call_pend) begin
         if (i_pos_mode && !in_limits) begin
            d.refused = 1'b1;
            d.limit_msg = i_msg_enable;
         end else begin
            d.call_pend = 1'b1;
            d.call_set = st_set;
            d.call_tgt = rec_mem[st_set][F_TGT];
            d.call_vel = rec_mem[st_set][F_PVEL];
            d.call_acc = rec_mem[st_set][F_ACC];
            d.call_dec = rec_mem[st_set][F_DEC];
            div_go = (q.jerk_mode == JERK_MODE_MAX);
         end
      end
      if (q.call_pend && !i_hold) begin
         d.call_pend = 1'b0;
         d.launch = 1'b1;
      end
      // A mode write in the same cycle wins over a late quotient
      if (div_done && d.jerk_mode == JERK_MODE_MAX) begin
         d.filter_time = div_quot;
         d.filter_valid = 1'b1;
      end
      // Deceleration keeps its old factor; acceleration is never scaled
      if (!i_braking)
         d.ovr_applied = q.ovr;
   end

   // State register; override restarts at full scale
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
         q.set_ptr <= SET_BUS;
         q.start_sel <= START_BUS_CODE;
         q.ovr <= OVR_FULL;
         q.ovr_applied <= OVR_FULL;
         q.lim_lo <= LIM_LO_RST;
         q.lim_hi <= LIM_HI_RST;
      end else begin
         q <= d;
      end
   end

   // Record storage; one process, so the array has a single writer
   always_ff @(posedge i_mclk) begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
         if (mem_we[f])
            rec_mem[mem_set][f] <= mem_wd;
      end
   end

   // Filter time from velocity magnitude over acceleration
   ppsm_divider u_div (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_go(div_go),
      .i_num(rec_mem[st_set][F_PVEL][31] ? -rec_mem[st_set][F_PVEL]
                                         : rec_mem[st_set][F_PVEL]),
      .i_den(rec_mem[st_set][F_ACC]),
      .o_quot(div_quot),
      .o_done(div_done)
   );

   // Velocity of the running move follows the override at once, except while braking
   ppsm_scale u_scale (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_vel(q.call_vel),
      .i_ovr(q.ovr_applied),
      .o_vel(o_vel_cmd)
   );

   assign o_ready = q.ready;
   assign o_ack = q.ack;
   assign o_err = q.err;
   assign o_rdata = q.rdata;
   assign o_launch = q.launch;
   assign o_call_set = q.call_set;
   assign o_call_target = q.call_tgt;
   assign o_call_accel = q.call_acc;
   assign o_call_decel = q.call_dec;
   assign o_refused = q.refused;
   assign o_limit_msg = q.limit_msg;
   assign o_filter_time = q.filter_time;
   assign o_filter_valid = q.filter_valid;
   assign o_nv_wr = q.nv_wr;
   assign o_nv_field = q.nv_fld;
   assign o_nv_data = q.nv_data;

   // Checks
   logic wr_ok;
   assign wr_ok = acc_req && i_wr;

   a_ptr_range: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      q.set_ptr <= SET_MAX) else $error("set pointer out of range");
   a_ptr_reject: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      wr_ok && i_pnu == PNU_SET_PTR && i_wdata > 32'h0000_010b
      |=> o_err && $stable(q.set_ptr)) else $error("bad pointer taken");
   a_both_write: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      wr_ok && i_pnu == PNU_RECORD && i_sub == 8'h05
      |=> rec_mem[ptr_set][F_ACC] == rec_mem[ptr_set][F_DEC]
          && rec_mem[ptr_set][F_ACC] == $past(i_wdata))
      else $error("combined write missed a field");
   a_both_read: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      acc_req && !i_wr && i_pnu == PNU_RECORD && i_sub == 8'h05
      |=> o_ack && o_rdata == $past(rec_mem[ptr_set][F_ACC]))
      else $error("combined read not acceleration");
   a_bus_start: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      i_start && q.ready && !q.call_pend && q.start_sel == 8'hff
      && !o_refused && !(i_pos_mode && !in_limits)
      |=> o_call_set == 9'h10a) else $error("255 not bus set");
   a_jerk_zero: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      wr_ok && i_pnu == PNU_JERK_MODE && i_wdata == 32'h0
      |=> o_filter_valid && o_filter_time == 32'h0)
      else $error("jerk not zeroed");
   a_jerk_calc: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      div_go && !acc_req |=> ##[1:40] o_filter_valid)
      else $error("filter time not recomputed");
   a_refuse: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      i_start && q.ready && !q.call_pend && i_pos_mode && !in_limits
      |=> o_refused && !q.call_pend ##1 !o_launch)
      else $error("out of limit start launched");
   a_ovr_range: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      q.ovr <= OVR_MAX) else $error("override out of range");
   a_ovr_brake: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      i_braking |=> $stable(q.ovr_applied))
      else $error("override changed while braking");

   c_launch: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      o_launch);
   c_refused: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      o_refused && o_limit_msg);
   c_both: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      wr_ok && i_pnu == PNU_RECORD && i_sub == 8'h05);
   c_filter: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      o_filter_valid && o_filter_time != 32'h0);
endmodule // ppsm_param_set

// ===== ppsm_ctrl_model.sv
`timescale 1ns/100ps
// Fieldbus controller: one parameter access at a time
module ppsm_ctrl_model (
   input wire logic i_mclk, // System clock
   input wire logic i_ack, // Access answered
   input wire logic i_err, // Access rejected
   input wire logic [31:0] i_rdata, // Read data
   output logic o_req, // Access request pulse
   output logic o_wr, // 1 write, 0 read
   output logic [15:0] o_pnu, // Parameter number
   output logic [7:0] o_sub, // Subindex
   output logic [31:0] o_wdata // Write data
);
   // Idle bus at time zero
   initial begin
      o_req = 1'h0;
      o_wr = 1'h0;
      o_pnu = 16'h0;
      o_sub = 8'h0;
      o_wdata = 32'h0;
   end
   // Request for one cycle; the answer is read in the cycle after it
   task automatic access(input logic w, input logic [15:0] p,
      input logic [7:0] s, input logic [31:0] d,
      output logic ack, output logic err, output logic [31:0] rd);
      @(posedge i_mclk);
      o_req <= 1'h1;
      o_wr <= w;
      o_pnu <= p;
      o_sub <= s;
      o_wdata <= d;
      @(posedge i_mclk);
      o_req <= 1'h0;
      #1;
      ack = i_ack;
      err = i_err;
      rd = i_rdata;
   endtask
   // Special sets: point at the set first, only then write the field
   task automatic set_write(input logic [15:0] set, input logic [7:0] s,
      input logic [31:0] d, output logic err);
      logic a;
      logic [31:0] r;
      access(1'h1, 16'h3e8, 8'h0, {16'h0, set}, a, err, r);
      access(1'h1, 16'h3e9, s, d, a, err, r);
   endtask
endmodule // ppsm_ctrl_model

// ===== ppsm_param_set_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module ppsm_param_set_test;
   import ppsm_pkg::*;
   typedef struct packed {
      logic wr; logic [15:0] pnu; logic [7:0] sub; logic [31:0] wd;
      logic err; logic [31:0] rd;
   } ppsm_row_s;
   logic i_mclk, i_resetn, i_req, i_wr, i_start, i_pos_mode, i_hold;
   logic i_braking, i_msg_enable, o_ready, o_ack, o_err, o_launch;
   logic o_refused, o_limit_msg, o_filter_valid, o_nv_wr, a_ack, a_err;
   logic [15:0] i_pnu;
   logic [7:0] i_sub;
   logic [8:0] o_call_set;
   logic [2:0] o_nv_field;
   logic [31:0] i_wdata, o_rdata, o_call_target, o_call_accel, a_rd;
   logic [31:0] o_call_decel, o_filter_time, o_nv_data;
   logic signed [31:0] o_vel_cmd;
   int err_total = 0, n_tests = 0, n_launch = 0, n_filt = 0, cnt;
   ppsm_row_s rows [27];
   ppsm_param_set u_ppsm_param_set (.i_mclk, .i_resetn, .i_req, .i_wr,
      .i_pnu, .i_sub, .i_wdata, .o_ready, .o_ack, .o_err, .o_rdata,
      .i_start, .i_pos_mode, .i_hold, .i_braking, .i_msg_enable, .o_launch,
      .o_call_set, .o_call_target, .o_call_accel, .o_call_decel, .o_vel_cmd,
      .o_refused, .o_limit_msg, .o_filter_time, .o_filter_valid, .o_nv_wr,
      .o_nv_field, .o_nv_data);
   ppsm_ctrl_model u_ppsm_ctrl_model (.i_mclk, .i_ack(o_ack), .i_err(o_err),
      .i_rdata(o_rdata), .o_req(i_req), .o_wr(i_wr), .o_pnu(i_pnu),
      .o_sub(i_sub), .o_wdata(i_wdata));
   initial begin
      i_mclk = 1'h0;
      forever #5 i_mclk = ~i_mclk;
   end
   // Pulse counters, so no single-cycle pulse slips by
   always @(posedge i_mclk) begin
      n_launch <= n_launch + int'(o_launch);
      n_filt <= n_filt + int'(o_filter_valid);
   end
   task automatic stop_test;
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Whole run is near 2900 cycles; about seven times that means a hang
   initial begin
      #200000;
      err_total++;
      stop_test;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic acc(input logic w, input logic [15:0] p,
      input logic [7:0] s, input logic [31:0] d);
      u_ppsm_ctrl_model.access(w, p, s, d, a_ack, a_err, a_rd);
      `CHK(a_ack, 1'h1)
   endtask
   task automatic start_call(input logic hold);
      @(posedge i_mclk);
      i_start <= 1'h1;
      i_hold <= hold;
      @(posedge i_mclk);
      i_start <= 1'h0;
      #1;
   endtask
   // Reset, probe during the init sweep, then wait for ready
   task automatic do_reset;
      @(posedge i_mclk);
      i_resetn <= 1'h0;
      repeat (10) @(posedge i_mclk);
      i_resetn <= 1'h1;
      u_ppsm_ctrl_model.access(1'h0, PNU_SET_PTR, 8'h0, 32'h0,
         a_ack, a_err, a_rd);
      `CHK(a_ack, 1'h0)
      cnt = 2;
      while (o_ready !== 1'h1 && cnt < 2000) begin
         cyc(1);
         cnt++;
      end
      `CHK(cnt inside {[1339:1341]}, 1'h1)
      `CHK({o_filter_valid, o_filter_time}, 33'h1_0000_0000)
   endtask
   initial begin
      i_resetn = 1'h0;
      i_start = 1'h0;
      i_pos_mode = 1'h0;
      i_hold = 1'h0;
      i_braking = 1'h0;
      i_msg_enable = 1'h0;
      rows = '{
         '{1'h0, 16'h3e8, 8'h0, 32'h0, 1'h0, 32'h10a},
         '{1'h0, 16'h3e9, 8'h0, 32'h0, 1'h0, 32'h0},
         '{1'h0, 16'h3e9, 8'h1, 32'h0, 1'h0, 32'h3e8},
         '{1'h0, 16'h3e9, 8'h2, 32'h0, 1'h0, 32'h0},
         '{1'h0, 16'h3e9, 8'h3, 32'h0, 1'h0, 32'h2710},
         '{1'h0, 16'h3e9, 8'h4, 32'h0, 1'h0, 32'h2710},
         '{1'h0, 16'h3ea, 8'h0, 32'h0, 1'h0, 32'hff},
         '{1'h0, 16'h3eb, 8'h0, 32'h0, 1'h0, 32'h0},
         '{1'h0, 16'h3ec, 8'h0, 32'h0, 1'h0, 32'h3e8},
         '{1'h0, 16'h3ed, 8'h0, 32'h0, 1'h0, 32'h8000_0000},
         '{1'h0, 16'h3ed, 8'h1, 32'h0, 1'h0, 32'h7fff_ffff},
         '{1'h1, 16'h3e9, 8'h5, 32'h1234, 1'h0, 32'h0},
         '{1'h0, 16'h3e9, 8'h3, 32'h0, 1'h0, 32'h1234},
         '{1'h0, 16'h3e9, 8'h4, 32'h0, 1'h0, 32'h1234},
         '{1'h1, 16'h3e9, 8'h4, 32'h55, 1'h0, 32'h0},
         '{1'h0, 16'h3e9, 8'h5, 32'h0, 1'h0, 32'h1234},
         '{1'h1, 16'h3e8, 8'h0, 32'h10c, 1'h1, 32'h0},
         '{1'h0, 16'h3e8, 8'h0, 32'h0, 1'h0, 32'h10a},
         '{1'h1, 16'h3ea, 8'h0, 32'h100, 1'h1, 32'h0},
         '{1'h1, 16'h3eb, 8'h0, 32'h2, 1'h1, 32'h0},
         '{1'h1, 16'h3ec, 8'h0, 32'h7d1, 1'h1, 32'h0},
         '{1'h1, 16'h3ec, 8'h0, 32'h7d0, 1'h0, 32'h0},
         '{1'h0, 16'h3ec, 8'h0, 32'h0, 1'h0, 32'h7d0},
         '{1'h1, 16'h3ec, 8'h0, 32'h3e8, 1'h0, 32'h0},
         '{1'h0, 16'h3ee, 8'h0, 32'h0, 1'h1, 32'h0},
         '{1'h0, 16'h3e9, 8'h6, 32'h0, 1'h1, 32'h0},
         '{1'h0, 16'h3ed, 8'h2, 32'h0, 1'h1, 32'h0}};
      do_reset;
      foreach (rows[k]) begin
         acc(rows[k].wr, rows[k].pnu, rows[k].sub, rows[k].wd);
         `CHK({a_err, a_rd}, {rows[k].err, rows[k].rd})
      end
      // Bus set field writes reach storage, other sets do not
      acc(1'h1, PNU_RECORD, 8'h5, 32'h64);
      `CHK({o_nv_wr, o_nv_field, o_nv_data}, {1'h1, 3'h5, 32'h64})
      acc(1'h1, PNU_RECORD, 8'h0, 32'h1f4);
      acc(1'h1, PNU_RECORD, 8'h1, 32'h7d0);
      u_ppsm_ctrl_model.set_write(16'h3, 8'h0, 32'h99, a_err);
      `CHK(o_nv_wr, 1'h0)
      acc(1'h1, PNU_SET_PTR, 8'h0, 32'h10a);
      // Call captured at once, launch held until the hold drops
      start_call(1'h1);
      `CHK({o_call_set, o_call_target, o_call_accel, o_call_decel},
         {9'h10a, 32'h1f4, 32'h64, 32'h64})
      cyc(4);
      `CHK(n_launch, 0)
      @(posedge i_mclk) i_hold <= 1'h0;
      cyc(3);
      `CHK(n_launch, 1)
      `CHK(o_vel_cmd, 32'h7d0)
      // Override halves speed; ignored while braking
      acc(1'h1, PNU_OVERRIDE, 8'h0, 32'h1f4);
      cyc(3);
      `CHK(o_vel_cmd, 32'h3e8)
      @(posedge i_mclk) i_braking <= 1'h1;
      acc(1'h1, PNU_OVERRIDE, 8'h0, 32'h5dc);
      cyc(3);
      `CHK(o_vel_cmd, 32'h3e8)
      @(posedge i_mclk) i_braking <= 1'h0;
      cyc(3);
      `CHK(o_vel_cmd, 32'hbb8)
      `CHK(o_call_accel, 32'h64)
      // Standard set started through the selector
      acc(1'h1, PNU_START_SEL, 8'h0, 32'h3);
      start_call(1'h0);
      `CHK({o_call_set, o_call_target}, {9'h3, 32'h99})
      cyc(2);
      acc(1'h1, PNU_START_SEL, 8'h0, 32'hff);
      // Target below the lower limit refused only in positioning mode
      acc(1'h1, PNU_LIMITS, 8'h0, 32'h200);
      @(posedge i_mclk) begin
         i_pos_mode <= 1'h1;
         i_msg_enable <= 1'h1;
      end
      start_call(1'h0);
      `CHK({o_refused, o_limit_msg}, 2'h3)
      cyc(3);
      `CHK(n_launch, 2)
      @(posedge i_mclk) i_pos_mode <= 1'h0;
      start_call(1'h0);
      `CHK(o_refused, 1'h0)
      cyc(2);
      `CHK(n_launch, 3)
      // Jerk mode 1: filter time from velocity over acceleration
      acc(1'h1, PNU_JERK_MODE, 8'h0, 32'h1);
      cnt = n_filt;
      start_call(1'h0);
      for (int k = 0; k < 40 && n_filt == cnt; k++)
         cyc(1);
      `CHK(o_filter_time, 32'h14)
      acc(1'h1, PNU_JERK_MODE, 8'h0, 32'h0);
      cnt = n_filt;
      cyc(3);
      `CHK({n_filt - cnt, o_filter_time}, {32'd1, 32'h0})
      // Second reset restores override and pointer
      do_reset;
      acc(1'h0, PNU_OVERRIDE, 8'h0, 32'h0);
      `CHK(a_rd, 32'h3e8)
      acc(1'h0, PNU_SET_PTR, 8'h0, 32'h0);
      `CHK(a_rd, 32'h10a)
      stop_test;
   end
endmodule // ppsm_param_set_test
